/* File: acg_top.sv */
// calibration engine, coefficient registers and external port gating
//
// Overview of operation
// - core port accesses during dma to external ram are silenced
// - dma to on-chip ram leaves ports free
// - during dma to external ram core reaches only on-chip ram
// - dma block done raises core interrupt
// - two 14-bit coefficients, 6+8 split registers
// - larger offset coefficient pushes transfer down
// - larger gain coefficient raises transfer slope
// - gain span 0.975 to 1.025 of reference
// - device calibration channels ground 1011, ref 1100
// - type bit and device bit choose mode
// - cycle lasts 14*clk*averages*(16+acq)
// - busy bit 7 spans whole calibration
// - sample control bit 6 enables dma
`timescale 1ns/1ps
module acg_top
  import acg_pkg::*;
#(
  parameter int SAMPLE_W = 12,
  parameter int AVG_MAX = 31
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire acg_sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  input wire acg_xmem_req_t core_xmem,
  input wire logic expanded_ram_en,
  input wire logic dma_onchip_target,
  input wire logic dma_block_done,
  input wire logic dma_irq_en,
  input wire logic [SAMPLE_W-1:0] conv_sample,
  output acg_xmem_req_t port_req,
  output logic onchip_ram_sel,
  output logic dma_done_irq,
  output logic [3:0] conv_channel
);

  ////////////////////////////////////////////////////////////////////
  // reset release through two flops
  // the assert stays asynchronous, only the release is lined up with the clock
  logic rst_s1_r;
  logic rst_s2_r;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  wire logic rst_n = rst_s2_r;

  // averaging count from the two-bit field; 31 is the top choice
  // field 3 follows AVG_MAX so a bench can shorten the run
  function automatic logic [4:0] avg_of(input logic [1:0] f);
    unique case (f)
      2'd0: avg_of = 5'd1;
      2'd1: avg_of = 5'd15;
      2'd2: avg_of = 5'd7;
      2'd3: avg_of = 5'(AVG_MAX);
    endcase
  endfunction

  // converter clock divide choice
  // a new ratio takes hold at the next tick, not at the write
  function automatic logic [5:0] div_of(input logic [1:0] f);
    unique case (f)
      2'd0: div_of = 6'd8;
      2'd1: div_of = 6'd4;
      2'd2: div_of = 6'd16;
      2'd3: div_of = 6'd32;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////
  // register file and calibration engine state
  logic [7:0] setup_r, setup_nxt;
  logic [7:0] sample_r, sample_nxt;
  logic [7:0] cal_r, cal_nxt;
  logic [COEFF_W-1:0] ofs_r, ofs_nxt;
  logic [COEFF_W-1:0] gain_r, gain_nxt;
  acg_state_t state_r, state_nxt;
  logic [5:0] div_cnt_r, div_cnt_nxt;
  logic [4:0] slot_cnt_r, slot_cnt_nxt;
  logic [3:0] step_cnt_r, step_cnt_nxt;
  logic [4:0] avg_cnt_r, avg_cnt_nxt;
  logic [19:0] acc_r, acc_nxt;
  logic [7:0] rdata_r, rdata_nxt;

  // helpers shared by the engine and the channel select
  logic conv_tick;
  logic cal_gain;
  logic [4:0] slots;
  logic [COEFF_W-1:0] result;
  logic [13:0] sample_ext;

  // divided clock tick, slots per conversion, widened sample
  assign conv_tick = (div_cnt_r == 6'd0);
  assign cal_gain = cal_r[CAL_TYPE_BIT];
  assign slots = 5'(CONV_BASE) + {3'b000, setup_r[SETUP_ACQ_LSB +: 2]} + 5'd1;
  assign sample_ext = {{(14-SAMPLE_W){1'b0}}, conv_sample};
  assign result = acc_r[COEFF_W-1:0];

  // mode, timing and bus writes resolved together
  // the divider runs freely, so the first tick of a run lands anywhere
  // within one divide period; the cycle length is exact only to that period
  always_comb begin
    setup_nxt = setup_r;
    sample_nxt = sample_r;
    cal_nxt = cal_r;
    ofs_nxt = ofs_r;
    gain_nxt = gain_r;
    state_nxt = state_r;
    div_cnt_nxt = conv_tick ? (div_of(setup_r[SETUP_DIV_LSB +: 2]) - 6'd1) : div_cnt_r - 6'd1;
    slot_cnt_nxt = slot_cnt_r;
    step_cnt_nxt = step_cnt_r;
    avg_cnt_nxt = avg_cnt_r;
    acc_nxt = acc_r;
    // bit 7 belongs to the engine, software writes to it are dropped
    // coefficient halves stay writable so software can load its own values
    if (sfr_req.wr) begin
      unique case (sfr_req.addr)
        ADDR_CONVERTER_SETUP: setup_nxt = sfr_req.wdata;
        ADDR_SAMPLE_CONTROL: sample_nxt = sfr_req.wdata;
        ADDR_CALIBRATION_CONTROL: cal_nxt = {cal_r[CAL_BUSY_BIT], sfr_req.wdata[6:0]};
        ADDR_OFFSET_COEFF_LOWER: ofs_nxt[7:0] = sfr_req.wdata;
        ADDR_OFFSET_COEFF_UPPER: ofs_nxt[13:8] = sfr_req.wdata[5:0];
        ADDR_GAIN_COEFF_LOWER: gain_nxt[7:0] = sfr_req.wdata;
        ADDR_GAIN_COEFF_UPPER: gain_nxt[13:8] = sfr_req.wdata[5:0];
        default: ;
      endcase
    end
    unique case (state_r)
      ACG_IDLE: begin
        // a start write raises busy at once
        // type and averaging written with the start apply to this run
        if (sfr_req.wr && sfr_req.addr == ADDR_CALIBRATION_CONTROL &&
            sfr_req.wdata[CAL_START_BIT]) begin
          cal_nxt[CAL_BUSY_BIT] = 1'b1;
          cal_nxt[CAL_START_BIT] = 1'b0;
          state_nxt = ACG_RUN;
          step_cnt_nxt = 4'(CAL_STEPS - 1);
          avg_cnt_nxt = avg_of(sfr_req.wdata[CAL_AVG_LSB +: 2]) - 5'd1;
          slot_cnt_nxt = slots - 5'd1;
          acc_nxt = 20'd0;
        end
      end
      ACG_RUN: begin
        // one conversion per slot group, counted on the divided clock
        if (conv_tick) begin
          if (slot_cnt_r != 5'd0) begin
            slot_cnt_nxt = slot_cnt_r - 5'd1;
          end else begin
            slot_cnt_nxt = slots - 5'd1;
            // the sum wraps at 20 bits, only its low 14 bits reach a coefficient
            acc_nxt = acc_r + {6'd0, sample_ext};
            if (avg_cnt_r != 5'd0) begin
              avg_cnt_nxt = avg_cnt_r - 5'd1;
            end else begin
              avg_cnt_nxt = avg_of(cal_r[CAL_AVG_LSB +: 2]) - 5'd1;
              if (step_cnt_r != 4'd0) begin
                step_cnt_nxt = step_cnt_r - 4'd1;
              end else begin
                state_nxt = ACG_STORE;
              end
            end
          end
        end
      end
      ACG_STORE: begin
        // offset: larger code pulls transfer down; gain: larger code steepens it
        // gain is mirrored around midscale so a low reading steepens the slope
        if (cal_gain) begin
          gain_nxt = COEFF_MID + (COEFF_MID - result);
        end else begin
          ofs_nxt = COEFF_MID + result;
        end
        cal_nxt[CAL_BUSY_BIT] = 1'b0;
        state_nxt = ACG_IDLE;
      end
      default: state_nxt = ACG_IDLE;
    endcase
  end

  // read mux, registered so the read data is a flop
  // unmapped addresses read as zero
  always_comb begin
    rdata_nxt = rdata_r;
    if (sfr_req.rd) begin
      unique case (sfr_req.addr)
        ADDR_CONVERTER_SETUP: rdata_nxt = setup_r;
        ADDR_SAMPLE_CONTROL: rdata_nxt = sample_r;
        ADDR_CALIBRATION_CONTROL: rdata_nxt = cal_r;
        ADDR_OFFSET_COEFF_LOWER: rdata_nxt = ofs_r[7:0];
        ADDR_OFFSET_COEFF_UPPER: rdata_nxt = {2'b00, ofs_r[13:8]};
        ADDR_GAIN_COEFF_LOWER: rdata_nxt = gain_r[7:0];
        ADDR_GAIN_COEFF_UPPER: rdata_nxt = {2'b00, gain_r[13:8]};
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  // register file, engine counters and read data
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      setup_r <= SETUP_RESET;
      sample_r <= SAMPLE_RESET;
      cal_r <= CAL_RESET;
      ofs_r <= COEFF_MID;
      gain_r <= COEFF_MID;
      state_r <= ACG_IDLE;
      div_cnt_r <= 6'h00;
      slot_cnt_r <= 5'h00;
      step_cnt_r <= 4'h0;
      avg_cnt_r <= 5'h00;
      acc_r <= 20'h00000;
      rdata_r <= 8'h00;
    end else begin
      setup_r <= setup_nxt;
      sample_r <= sample_nxt;
      cal_r <= cal_nxt;
      ofs_r <= ofs_nxt;
      gain_r <= gain_nxt;
      state_r <= state_nxt;
      div_cnt_r <= div_cnt_nxt;
      slot_cnt_r <= slot_cnt_nxt;
      step_cnt_r <= step_cnt_nxt;
      avg_cnt_r <= avg_cnt_nxt;
      acc_r <= acc_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // external port gating and interrupt
  acg_xmem_req_t port_nxt, port_r;
  logic onchip_nxt, onchip_r;
  logic irq_nxt, irq_r;
  logic [3:0] chan_nxt, chan_r;
  logic dma_on;
  logic dma_external;

  // who owns the pins and the on-chip ram while dma runs
  assign dma_on = sample_r[SAMPLE_DMA_BIT];
  assign dma_external = dma_on && !dma_onchip_target;

  // instructions still complete, only the pins stay quiet
  // the gate sits ahead of the port flop, so it costs no extra cycle
  always_comb begin
    port_nxt = core_xmem;
    onchip_nxt = expanded_ram_en && (core_xmem.rd || core_xmem.wr);
    if (dma_external) begin
      // pins belong to dma, only the on-chip ram stays reachable
      port_nxt.rd = 1'b0;
      port_nxt.wr = 1'b0;
      onchip_nxt = expanded_ram_en && (core_xmem.rd || core_xmem.wr);
    end else if (dma_on) begin
      // dma fills the on-chip ram, the pins go back to the core
      port_nxt = core_xmem;
      onchip_nxt = 1'b0;
    end
    // the pulse only means something while dma is on
    irq_nxt = dma_on && dma_irq_en && dma_block_done;
    // the internal channel is forced only for device calibration
    chan_nxt = sample_r[3:0];
    if (state_r != ACG_IDLE && cal_r[CAL_DEVICE_BIT]) begin
      chan_nxt = cal_gain ? CH_INT_REF : CH_INT_GROUND;
    end
  end

  // gating, interrupt and channel flops
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_r <= '0;
      onchip_r <= 1'b0;
      irq_r <= 1'b0;
      chan_r <= 4'h0;
    end else begin
      port_r <= port_nxt;
      onchip_r <= onchip_nxt;
      irq_r <= irq_nxt;
      chan_r <= chan_nxt;
    end
  end

  // outputs straight from their flops
  assign sfr_rdata = rdata_r;
  assign port_req = port_r;
  assign onchip_ram_sel = onchip_r;
  assign dma_done_irq = irq_r;
  assign conv_channel = chan_r;

endmodule

/* File: acg_pkg.sv */
// package for the converter calibration and bus gating block
package acg_pkg;

  localparam int COEFF_W = 14;
  localparam int COEFF_HI_W = 6;
  localparam int COEFF_LO_W = 8;
  localparam logic [13:0] COEFF_MID = 14'h2000;

  // special-function register addresses, chosen for this block
  localparam logic [7:0] ADDR_CONVERTER_SETUP = 8'hEF;
  localparam logic [7:0] ADDR_SAMPLE_CONTROL = 8'hD8;
  localparam logic [7:0] ADDR_CALIBRATION_CONTROL = 8'hF5;
  localparam logic [7:0] ADDR_OFFSET_COEFF_LOWER = 8'hF1;
  localparam logic [7:0] ADDR_OFFSET_COEFF_UPPER = 8'hF2;
  localparam logic [7:0] ADDR_GAIN_COEFF_LOWER = 8'hF3;
  localparam logic [7:0] ADDR_GAIN_COEFF_UPPER = 8'hF4;

  // field positions
  localparam int CAL_BUSY_BIT = 7;
  localparam int CAL_TYPE_BIT = 1;
  localparam int CAL_START_BIT = 0;
  localparam int CAL_AVG_LSB = 2;
  localparam int CAL_DEVICE_BIT = 6;
  localparam int SAMPLE_DMA_BIT = 6;
  localparam int SETUP_DIV_LSB = 4;
  localparam int SETUP_ACQ_LSB = 2;

  // channel codes for device calibration
  localparam logic [3:0] CH_INT_GROUND = 4'hB;
  localparam logic [3:0] CH_INT_REF = 4'hC;

  // cycle timing
  localparam int CAL_STEPS = 14;
  localparam int CONV_BASE = 16;

  localparam logic [7:0] SETUP_RESET = 8'h00;
  localparam logic [7:0] SAMPLE_RESET = 8'h00;
  localparam logic [7:0] CAL_RESET = 8'h00;

  typedef enum logic [1:0] {
    ACG_IDLE = 2'b00,
    ACG_RUN = 2'b01,
    ACG_STORE = 2'b11
  } acg_state_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } acg_sfr_req_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } acg_xmem_req_t;

endpackage

/* File: acg_monitor.sv */
// assertion checker for the calibration and port gating block
`timescale 1ns/1ps
module acg_monitor
  import acg_pkg::*;
#(
  parameter int SAMPLE_W = 12,
  parameter int AVG_MAX = 31
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire acg_sfr_req_t sfr_req,
  input wire logic [7:0] sfr_rdata,
  input wire acg_xmem_req_t core_xmem,
  input wire logic expanded_ram_en,
  input wire logic dma_onchip_target,
  input wire logic dma_block_done,
  input wire logic dma_irq_en,
  input wire logic [SAMPLE_W-1:0] conv_sample,
  input wire acg_xmem_req_t port_req,
  input wire logic onchip_ram_sel,
  input wire logic dma_done_irq,
  input wire logic [3:0] conv_channel
);
  logic dma_r;
  logic dma_nxt;
  logic gate;
  logic cal_wr;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////
  // mirror of the dma enable, the checker cannot see the register
  always_comb begin
    dma_nxt = dma_r;
    if (sfr_req.wr && sfr_req.addr == ADDR_SAMPLE_CONTROL) dma_nxt = sfr_req.wdata[SAMPLE_DMA_BIT];
  end
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) dma_r <= 1'b0;
    else dma_r <= dma_nxt;
  end
  // ports belong to dma only when its target is external
  assign gate = dma_r && !dma_onchip_target;
  assign cal_wr = sfr_req.wr && sfr_req.addr == ADDR_CALIBRATION_CONTROL && sfr_req.wdata[0];
  ////////////////////////////////////////
  a_port_gated: assert property (gate |=> !port_req.rd && !port_req.wr)
    else $error("core strobe reached ports during dma");
  a_port_pass: assert property (!gate |=> port_req == $past(core_xmem))
    else $error("port request differs from core request");
  a_onchip_block: assert property (gate && !expanded_ram_en |=> !onchip_ram_sel)
    else $error("on-chip select with ram disabled");
  a_onchip_dma: assert property (dma_r && dma_onchip_target |=> !onchip_ram_sel)
    else $error("on-chip select while dma fills that ram");
  a_irq_fire: assert property (dma_r && dma_block_done && dma_irq_en |=> dma_done_irq)
    else $error("block done gave no interrupt");
  a_irq_cause: assert property (dma_done_irq |-> $past(dma_r) && $past(dma_block_done) &&
    $past(dma_irq_en))
    else $error("interrupt without enabled block done");
  a_upper_width: assert property (sfr_req.rd && sfr_req.addr inside {8'hF2, 8'hF4}
    |=> sfr_rdata[7:6] == 2'b00)
    else $error("upper coefficient wider than six bits");
  a_ground_chan: assert property (cal_wr && sfr_req.wdata[6] && !sfr_req.wdata[1]
    |-> ##[1:2] conv_channel == CH_INT_GROUND)
    else $error("offset calibration not on ground");
  a_ref_chan: assert property (cal_wr && sfr_req.wdata[6] && sfr_req.wdata[1]
    |-> ##[1:2] conv_channel == CH_INT_REF)
    else $error("gain calibration not on reference");
endmodule
bind acg_top acg_monitor #(.SAMPLE_W(SAMPLE_W), .AVG_MAX(AVG_MAX)) acg_monitor_u (.ref_clk, .rst_b,
  .sfr_req, .sfr_rdata, .core_xmem, .expanded_ram_en, .dma_onchip_target, .dma_block_done,
  .dma_irq_en, .conv_sample, .port_req, .onchip_ram_sel, .dma_done_irq, .conv_channel);

/* File: acg_sram_model.sv */
// external static ram model on the multiplexed ports
`timescale 1ns/1ps
module acg_sram_model
  import acg_pkg::*;
(
  input wire logic ref_clk,
  input wire acg_xmem_req_t port_req,
  output logic [15:0] port_hits
);
  logic [7:0] mem [256];
  initial port_hits = 16'h0000;
  ////////////////////////////////////////
  // every strobe is counted so a leak past the gate shows up
  always @(posedge ref_clk) begin
    if (port_req.wr) mem[port_req.addr[7:0]] <= port_req.wdata;
    if (port_req.rd || port_req.wr) port_hits <= port_hits + 16'h0001;
  end
endmodule

/* File: testbench.sv */
// self-checking bench for the calibration and port gating block
`timescale 1ns/1ps
module testbench;
  import acg_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  acg_sfr_req_t sfr_req = '0;
  acg_xmem_req_t core_xmem = '0;
  logic expanded_ram_en = 1'b0;
  logic dma_onchip_target = 1'b0;
  logic dma_block_done = 1'b0;
  logic dma_irq_en = 1'b0;
  logic [11:0] conv_sample = 12'h000;
  logic [7:0] sfr_rdata;
  acg_xmem_req_t port_req;
  logic onchip_ram_sel;
  logic dma_done_irq;
  logic [3:0] conv_channel;
  logic [15:0] port_hits;
  logic [15:0] h;
  logic dma_on = 1'b0;
  logic [7:0] rd_val;
  logic [7:0] a;
  logic [7:0] w;
  logic [13:0] c0;
  logic [13:0] c1;
  int miscompares = 0;
  int compares = 0;
  acg_top #(.SAMPLE_W(12)) dut_u (.ref_clk, .rst_b, .sfr_req, .sfr_rdata, .core_xmem,
    .expanded_ram_en, .dma_onchip_target, .dma_block_done, .dma_irq_en, .conv_sample,
    .port_req, .onchip_ram_sel, .dma_done_irq, .conv_channel);
  acg_sram_model ram_u (.ref_clk, .port_req, .port_hits);
  ////////////////////////////////////////
  // 200 MHz clock
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // idle cycle after each write so the strobe never rises at its own falling step
  task automatic sfr_wr(input logic [7:0] ad, input logic [7:0] d);
    sfr_req = '{1'b0, 1'b1, ad, d};
    @(negedge ref_clk);
    sfr_req = '0;
    if (ad == ADDR_SAMPLE_CONTROL) dma_on = d[SAMPLE_DMA_BIT];
    @(negedge ref_clk);
  endtask
  task automatic sfr_rd(input logic [7:0] ad);
    sfr_req = '{1'b1, 1'b0, ad, 8'h00};
    @(negedge ref_clk);
    sfr_req = '0;
    @(negedge ref_clk);
    rd_val = sfr_rdata;
  endtask
  function automatic int cal_cycles(input int div, input int acq, input int avg);
    return 14 * div * avg * (16 + acq);
  endfunction
  // random core traffic, ports compared one cycle later
  task automatic traffic(input int n);
    logic [25:0] r;
    logic g;
    logic sel_exp;
    repeat (n) begin
      r = 26'($urandom);
      core_xmem = r;
      expanded_ram_en = 1'($urandom);
      g = dma_on && !dma_onchip_target;
      // on-chip ram belongs to dma whenever it is the target
      sel_exp = expanded_ram_en && (r[25] || r[24]) && !(dma_on && dma_onchip_target);
      @(negedge ref_clk);
      if (g) check({port_req.rd, port_req.wr}, 2'b00);
      else check(port_req, r);
      check(onchip_ram_sel, sel_exp);
    end
    core_xmem = '0;
  endtask
  // one calibration: channel, busy span, cycle length, stored coefficient
  task automatic calib(input logic [7:0] cmd, input logic [3:0] ch, input logic [11:0] smp,
                       input int div, input int n_cyc, output logic [13:0] coef);
    int n;
    // settle the divider on its ratio so the first tick falls within one period
    repeat (32) @(negedge ref_clk);
    conv_sample = smp;
    sfr_wr(ADDR_CALIBRATION_CONTROL, cmd);
    check(conv_channel, ch);
    sfr_rd(ADDR_CALIBRATION_CONTROL);
    check(rd_val[CAL_BUSY_BIT], 1'b1);
    repeat (n_cyc - 26) @(negedge ref_clk);
    sfr_rd(ADDR_CALIBRATION_CONTROL);
    check(rd_val[CAL_BUSY_BIT], 1'b1);
    n = 0;
    do begin
      sfr_rd(ADDR_CALIBRATION_CONTROL);
      n++;
    end while (rd_val[CAL_BUSY_BIT] !== 1'b0 && n < 30);
    // busy may clear up to one divide period early, never more than one cycle late
    check(n >= (26 - div) / 2 && n <= 12, 1'b1);
    sfr_rd(cmd[CAL_TYPE_BIT] ? ADDR_GAIN_COEFF_UPPER : ADDR_OFFSET_COEFF_UPPER);
    coef[13:8] = rd_val[5:0];
    sfr_rd(cmd[CAL_TYPE_BIT] ? ADDR_GAIN_COEFF_LOWER : ADDR_OFFSET_COEFF_LOWER);
    coef[7:0] = rd_val;
  endtask
  ////////////////////////////////////////
  initial begin
    void'($urandom(32'h97C0C014));
    repeat (6) @(negedge ref_clk);
    rst_b = 1'b1;
    repeat (3) @(negedge ref_clk);
    // coefficient halves: midscale reset, six-bit upper, then an unmapped hole
    for (int i = 0; i < 4; i++) begin
      a = ADDR_OFFSET_COEFF_LOWER + 8'(i);
      w = 8'($urandom);
      sfr_rd(a);
      check(rd_val, a[0] ? 8'h00 : 8'h20);
      sfr_wr(a, w);
      sfr_rd(a);
      check(rd_val, a[0] ? w : {2'b00, w[5:0]});
    end
    sfr_rd(8'h80);
    check(rd_val, 8'h00);
    // block-done interrupt with and without the enable, dma off and on
    for (int e = 0; e < 4; e++) begin
      sfr_wr(ADDR_SAMPLE_CONTROL, {1'b0, e[1], 6'h00});
      dma_irq_en = e[0];
      dma_block_done = 1'b1;
      @(negedge ref_clk);
      dma_block_done = 1'b0;
      check(dma_done_irq, e[0] & e[1]);
      @(negedge ref_clk);
      check(dma_done_irq, 1'b0);
    end
    // dma external, dma on-chip, dma off
    sfr_wr(ADDR_SAMPLE_CONTROL, 8'h40);
    for (int t = 0; t < 3; t++) begin
      dma_onchip_target = t[0];
      if (t == 2) sfr_wr(ADDR_SAMPLE_CONTROL, 8'h00);
      h = port_hits;
      traffic(40);
      if (t == 0) check(port_hits, h);
      else check(port_hits > h, 1'b1);
    end
    // device mode ignores the channel field, offset before gain
    sfr_wr(ADDR_SAMPLE_CONTROL, 8'h05);
    sfr_wr(ADDR_CONVERTER_SETUP, 8'h2C);
    calib(8'h41, CH_INT_GROUND, 12'h002, 16, cal_cycles(16, 4, 1), c0);
    calib(8'h41, CH_INT_GROUND, 12'h040, 16, cal_cycles(16, 4, 1), c1);
    check(c1 > c0, 1'b1);
    calib(8'h43, CH_INT_REF, 12'hFF0, 16, cal_cycles(16, 4, 1), c0);
    calib(8'h43, CH_INT_REF, 12'hF00, 16, cal_cycles(16, 4, 1), c1);
    check(c1 > c0, 1'b1);
    // system offset through the channel field
    sfr_wr(ADDR_SAMPLE_CONTROL, 8'h0B);
    sfr_wr(ADDR_CONVERTER_SETUP, 8'h10);
    calib(8'h25, 4'hB, 12'h000, 4, cal_cycles(4, 1, 15), c0);
    // corner: divide 8, seven averages, device gain overrides field 1011
    sfr_wr(ADDR_CONVERTER_SETUP, 8'h00);
    calib(8'h4B, CH_INT_REF, 12'h001, 8, cal_cycles(8, 1, 7), c1);
    final_report();
  end
endmodule
